// file: logic/ieu_arbiter.sv
// Two-level fixed-order arbiter for the interrupt enable and priority unit
`timescale 1ns/1ps
`include "ieu_cfg.svh"

module ieu_arbiter
    import ieu_pkg::*;
#(
    parameter int NSRC = `IEU_NUM_SRC
) (
    // Candidate requests and their levels
    input wire logic [NSRC-1:0] req_i,
    input wire logic [NSRC-1:0] high_i,
    // Winner
    output logic win_o,
    output logic win_high_o,
    output logic [`IEU_ID_W-1:0] win_id_o
);

    logic hi_hit;
    logic lo_hit;
    logic [`IEU_ID_W-1:0] hi_idx;
    logic [`IEU_ID_W-1:0] lo_idx;
    logic [`IEU_ID_W-1:0] pick;

    // Scan downward so the lowest index of each level is left standing
    always_comb begin
        hi_hit = 1'b0;
        lo_hit = 1'b0;
        hi_idx = '0;
        lo_idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req_i[i] && high_i[i]) begin
                hi_hit = 1'b1;
                hi_idx = i[`IEU_ID_W-1:0];
            end
            if (req_i[i] && !high_i[i]) begin
                lo_hit = 1'b1;
                lo_idx = i[`IEU_ID_W-1:0];
            end
        end
    end

    // High level first, then map index to the source's order number
    always_comb begin
        pick = hi_hit ? hi_idx : lo_idx;
        win_o = hi_hit | lo_hit;
        win_high_o = hi_hit;
        if (pick >= `IEU_ID_W'(`IEU_NUM_PRI)) begin
            win_id_o = pick + `IEU_ID_GAP;
        end else begin
            win_id_o = pick;
        end
    end

endmodule : ieu_arbiter

// file: logic/ieu_cfg.svh
// Constants for the interrupt enable and priority unit
`ifndef IEU_CFG_SVH
`define IEU_CFG_SVH

`define IEU_NUM_SRC 10
`define IEU_NUM_PRI 7
`define IEU_ID_W 4

// Register addresses
`define IEU_ADDR_EN_MAIN 8'ha8
`define IEU_ADDR_PRI_MAIN 8'hb8
`define IEU_ADDR_EN_EXT 8'he6

// Field positions
`define IEU_BIT_GLOBAL 3'd7
`define IEU_BIT_PRI_FIXED 3'd7
`define IEU_EXT_LO 2
`define IEU_EXT_HI 4

// Reset values
`define IEU_RST_EN_MAIN 8'h00
`define IEU_RST_PRI_MAIN 7'h00
`define IEU_RST_EN_EXT 3'h0

// Sources past the main register skip two unused identity slots
`define IEU_ID_GAP 4'h2

`endif

// file: logic/ieu_pkg.sv
// Types shared by the interrupt enable and priority unit
`include "ieu_cfg.svh"

package ieu_pkg;

    typedef logic [`IEU_NUM_SRC-1:0] ieu_src_vec_t;

    // Whole state of the unit
    typedef struct packed {
        logic [7:0] en_main;
        logic [6:0] pri_main;
        logic [2:0] en_ext;
        logic svc_lo;
        logic svc_hi;
        logic req;
        logic high;
        logic [`IEU_ID_W-1:0] id;
        logic [7:0] rdata;
        logic bit_rdata;
    } ieu_state_t;

endpackage : ieu_pkg

// file: logic/ieu_unit.sv
// Interrupt enable, priority and request arbitration toward the core
`timescale 1ns/1ps
`include "ieu_cfg.svh"

module ieu_unit
    import ieu_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Special function register byte port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    // Special function register bit port
    input wire logic [7:0] sfr_bit_addr_i,
    input wire logic sfr_bit_wr_i,
    input wire logic sfr_bit_rd_i,
    input wire logic sfr_bit_wdata_i,
    // Pending flags held by the peripherals
    input wire logic ext_edge_0_flag_i,
    input wire logic first_timer_overflow_i,
    input wire logic temp_demod_flag_i,
    input wire logic tick_timer_flag_i,
    input wire logic serializer_flag_i,
    input wire logic second_timer_low_overflow_i,
    input wire logic second_timer_high_overflow_i,
    input wire logic ext_edge_1_flag_i,
    input wire logic freq_counter_done_i,
    input wire logic soft_source_0_flag_i,
    input wire logic soft_source_1_flag_i,
    // Core handshake
    input wire logic irq_ack_i,
    input wire logic irq_ret_i,
    // Register read data
    output logic [7:0] sfr_rdata_o,
    output logic sfr_bit_rdata_o,
    // Request toward the core
    output logic irq_req_o,
    output logic irq_high_o,
    output logic [`IEU_ID_W-1:0] irq_id_o,
    output logic [1:0] in_service_o
);

    localparam int NSRC = `IEU_NUM_SRC;
    // Bit-address slots of the two bit-reachable registers
    localparam logic [4:0] EN_SLOT = 5'(`IEU_ADDR_EN_MAIN >> 3);
    localparam logic [4:0] PRI_SLOT = 5'(`IEU_ADDR_PRI_MAIN >> 3);

    ieu_state_t st_q;
    ieu_state_t st_d;

    ieu_src_vec_t pend;
    ieu_src_vec_t enabled;
    ieu_src_vec_t level_hi;
    ieu_src_vec_t eligible;
    logic global_on;
    logic arb_win;
    logic arb_high;
    logic [`IEU_ID_W-1:0] arb_id;
    logic [4:0] bit_byte;
    logic [2:0] bit_pos;

    // Pending flags in fixed order; only read, never cleared here
    always_comb begin
        pend[0] = ext_edge_0_flag_i;
        pend[1] = first_timer_overflow_i;
        pend[2] = temp_demod_flag_i;
        pend[3] = tick_timer_flag_i;
        pend[4] = serializer_flag_i;
        pend[5] = second_timer_low_overflow_i
                | second_timer_high_overflow_i;
        pend[6] = ext_edge_1_flag_i;
        pend[7] = freq_counter_done_i;
        pend[8] = soft_source_0_flag_i;
        pend[9] = soft_source_1_flag_i;
    end

    // Per-source enables and levels; last three sources sit at low level
    always_comb begin
        global_on = st_q.en_main[`IEU_BIT_GLOBAL];
        enabled = {st_q.en_ext, st_q.en_main[6:0]};
        level_hi = {3'h0, st_q.pri_main};
    end

    // Held flags stay visible while masked, so they win later
    always_comb begin
        eligible = pend & enabled & {NSRC{global_on}};
        if (st_q.svc_hi) begin
            eligible = '0;
        end else if (st_q.svc_lo) begin
            eligible = eligible & level_hi;
        end
    end

    ieu_arbiter #(
        .NSRC(NSRC)
    ) u_arb (
        .req_i(eligible),
        .high_i(level_hi),
        .win_o(arb_win),
        .win_high_o(arb_high),
        .win_id_o(arb_id)
    );

    // Bit address splits into register slot and bit number
    always_comb begin
        bit_byte = sfr_bit_addr_i[7:3];
        bit_pos = sfr_bit_addr_i[2:0];
    end

    // Byte view of a register as software reads it
    function automatic logic [7:0] read_byte(input logic [7:0] a,
                                             input ieu_state_t s);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            `IEU_ADDR_EN_MAIN: r = s.en_main;
            `IEU_ADDR_PRI_MAIN: r = {1'b1, s.pri_main};
            `IEU_ADDR_EN_EXT: r = {3'h0, s.en_ext, 2'h0};
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_byte

    // Next state: service tracking, register writes, reads, arbitration
    always_comb begin
        logic [7:0] bbyte;
        bbyte = read_byte({bit_byte, 3'h0}, st_q);
        st_d = st_q;

        // Return ends the deepest level running
        if (irq_ret_i) begin
            if (st_q.svc_hi) begin
                st_d.svc_hi = 1'b0;
            end else begin
                st_d.svc_lo = 1'b0;
            end
        end
        // Vectoring only marks the level; flags are left to software
        if (irq_ack_i && st_q.req) begin
            if (st_q.high) begin
                st_d.svc_hi = 1'b1;
            end else begin
                st_d.svc_lo = 1'b1;
            end
        end

        // Byte writes
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                `IEU_ADDR_EN_MAIN: st_d.en_main = sfr_wdata_i;
                `IEU_ADDR_PRI_MAIN: st_d.pri_main = sfr_wdata_i[6:0];
                `IEU_ADDR_EN_EXT: begin
                    st_d.en_ext = sfr_wdata_i[`IEU_EXT_HI:`IEU_EXT_LO];
                end
                default: st_d.en_main = st_d.en_main;
            endcase
        end

        // Single-bit writes; the extended register has no bit access
        if (sfr_bit_wr_i) begin
            if (bit_byte == EN_SLOT) begin
                st_d.en_main[bit_pos] = sfr_bit_wdata_i;
            end else if (bit_byte == PRI_SLOT) begin
                if (bit_pos != `IEU_BIT_PRI_FIXED) begin
                    st_d.pri_main[bit_pos] = sfr_bit_wdata_i;
                end
            end
        end

        // Read data holds until the next read strobe
        if (sfr_rd_i) begin
            st_d.rdata = read_byte(sfr_addr_i, st_q);
        end
        if (sfr_bit_rd_i) begin
            if (bit_byte == EN_SLOT
                || bit_byte == PRI_SLOT) begin
                st_d.bit_rdata = bbyte[bit_pos];
            end else begin
                st_d.bit_rdata = 1'b0;
            end
        end

        // Fresh decision each cycle from registered enables
        // A taken request drops for one cycle, so the core cannot take it
        // twice before the in-service mark starts to block its level
        st_d.req = arb_win && !(irq_ack_i && st_q.req);
        st_d.high = arb_high;
        st_d.id = arb_id;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q.en_main <= `IEU_RST_EN_MAIN;
            st_q.pri_main <= `IEU_RST_PRI_MAIN;
            st_q.en_ext <= `IEU_RST_EN_EXT;
            st_q.svc_lo <= 1'b0;
            st_q.svc_hi <= 1'b0;
            st_q.req <= 1'b0;
            st_q.high <= 1'b0;
            st_q.id <= '0;
            st_q.rdata <= 8'h00;
            st_q.bit_rdata <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        sfr_rdata_o = st_q.rdata;
        sfr_bit_rdata_o = st_q.bit_rdata;
        irq_req_o = st_q.req;
        irq_high_o = st_q.high;
        irq_id_o = st_q.id;
        in_service_o = {st_q.svc_hi, st_q.svc_lo};
    end

    // Checks on the unit's own behaviour

    no_req_global_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !st_q.en_main[`IEU_BIT_GLOBAL] |=> !irq_req_o)
        else $error("request while globally disabled");

    ext1_gate_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o == 4'h6 |-> $past(st_q.en_main[6]))
        else $error("edge source 1 passed while masked");

    timer2_gate_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o == 4'h5 |->
            $past(second_timer_low_overflow_i
                  || second_timer_high_overflow_i)
            && $past(st_q.en_main[5]))
        else $error("second timer request without cause");

    low_gates_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o < 4'h5 |->
            (($past(st_q.en_main) >> irq_id_o) & 8'h01) != 8'h00)
        else $error("main source passed while masked");

    en_write_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sfr_wr_i && sfr_addr_i == `IEU_ADDR_EN_MAIN
        ##1 sfr_rd_i && sfr_addr_i == `IEU_ADDR_EN_MAIN
            && !sfr_wr_i && !sfr_bit_wr_i
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("enable byte write not read back");

    pri_bit_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sfr_bit_wr_i && sfr_bit_addr_i == 8'hbb && !sfr_wr_i
        |=> st_q.pri_main[3] == $past(sfr_bit_wdata_i))
        else $error("priority bit write lost");

    pri_top_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `IEU_ADDR_PRI_MAIN |=> sfr_rdata_o[7])
        else $error("priority top bit read zero");

    ext_gate_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o >= 4'h9 |->
            (($past(st_q.en_ext) >> (irq_id_o - 4'h9)) & 3'h1) != 3'h0)
        else $error("extended source passed while masked");

    ext_reserved_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `IEU_ADDR_EN_EXT |=>
            sfr_rdata_o[7:5] == 3'h0 && sfr_rdata_o[1:0] == 2'h0)
        else $error("extended reserved bits read nonzero");

    high_hold_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_q.svc_hi |=> !irq_req_o)
        else $error("preemption of high level service");

    low_preempt_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_q.svc_lo && !st_q.svc_hi |=> !irq_req_o || irq_high_o)
        else $error("low request during low service");

    level_win_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (eligible & level_hi) != '0 && !(irq_ack_i && irq_req_o)
        |=> irq_req_o && irq_high_o)
        else $error("high level lost arbitration");

    pend_served_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !st_q.svc_lo && !st_q.svc_hi && global_on
        && (pend & enabled) != '0 && !(irq_ack_i && irq_req_o)
        |=> irq_req_o)
        else $error("enabled pending flag not requested");

    rearb_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        arb_win && !(irq_ack_i && irq_req_o)
        |=> irq_req_o && irq_id_o == $past(arb_id))
        else $error("winner not presented next cycle");

    take_drop_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_ack_i && irq_req_o |=> !irq_req_o)
        else $error("request still shown after it was taken");

    hi_mark_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_ack_i && irq_req_o && irq_high_o |=> in_service_o[1])
        else $error("high level not marked in service");

    lo_mark_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_ack_i && irq_req_o && !irq_high_o |=> in_service_o[0])
        else $error("low level not marked in service");

    ret_order_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_ret_i && !irq_ack_i && in_service_o == 2'h3
        |=> in_service_o == 2'h1)
        else $error("return did not end the high level first");

    pri_top_bit_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sfr_bit_rd_i && sfr_bit_addr_i == 8'hbf |=> sfr_bit_rdata_o)
        else $error("priority top bit read zero by bit");

    id_range_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o |-> irq_id_o != 4'h7 && irq_id_o != 4'h8
            && irq_id_o <= 4'hb)
        else $error("winner identity outside the source table");

    ext_low_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o >= 4'h9 |-> !irq_high_o)
        else $error("extended source shown at high level");

    main_level_a:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_req_o && irq_id_o < 4'h7 |-> irq_high_o
            == ((($past(st_q.pri_main) >> irq_id_o) & 7'h01) != 7'h00))
        else $error("winner level differs from its priority bit");

endmodule : ieu_unit

// file: testbench/ieu_core_model.sv
// Behavioural core that takes vectored requests and returns after a delay
`timescale 1ns/1ps

module ieu_core_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Request from the unit and service length in cycles
    input wire logic irq_req_i,
    input wire logic [3:0] svc_len_i,
    // Handshake back to the unit
    output logic irq_ack_o,
    output logic irq_ret_o
);
    int depth;
    int timer;

    // Ack a presented request, return once the routine has run its length
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            depth = 0;
            timer = 0;
            irq_ack_o <= 1'b0;
            irq_ret_o <= 1'b0;
        end else begin
            irq_ack_o <= 1'b0;
            irq_ret_o <= 1'b0;
            // The request stays up one cycle past an ack, so skip that one
            if (irq_req_i && !irq_ack_o) begin
                depth++;
                timer = svc_len_i;
                irq_ack_o <= 1'b1;
            end else if (depth > 0 && !irq_ack_o && !irq_ret_o) begin
                if (timer == 0) begin
                    depth--;
                    timer = svc_len_i;
                    irq_ret_o <= 1'b1;
                end else begin
                    timer--;
                end
            end
        end
    end
endmodule : ieu_core_model

// file: testbench/interrupt_enable_priority_unit_test.sv
// Self-checking bench for the interrupt enable and priority unit
`timescale 1ns/1ps

module interrupt_enable_priority_unit_test;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_bit_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic sfr_bit_wr_i = 1'b0;
    logic sfr_bit_rd_i = 1'b0;
    logic sfr_bit_wdata_i = 1'b0;
    logic [10:0] fl = 11'h000;
    logic [3:0] svc_len_i = 4'h0;
    logic irq_ack_i, irq_ret_i, irq_req_o, irq_high_o, sfr_bit_rdata_o;
    logic [7:0] sfr_rdata_o;
    logic [3:0] irq_id_o;
    logic [1:0] in_service_o;
    logic chk_on = 1'b0;
    logic [7:0] maps [4] = '{8'ha8, 8'hb8, 8'he6, 8'h00};
    int seed = 66;
    int mismatches = 0;
    int checks_done = 0;
    int m_en, m_pri, m_ext, m_svc, m_rd, m_brd, m_req, m_hi, m_id;

    ieu_unit u_ieu_unit (
        .sys_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
        .sfr_bit_addr_i, .sfr_bit_wr_i, .sfr_bit_rd_i, .sfr_bit_wdata_i,
        .ext_edge_0_flag_i(fl[0]), .first_timer_overflow_i(fl[1]),
        .temp_demod_flag_i(fl[2]), .tick_timer_flag_i(fl[3]),
        .serializer_flag_i(fl[4]), .second_timer_low_overflow_i(fl[5]),
        .second_timer_high_overflow_i(fl[6]), .ext_edge_1_flag_i(fl[7]),
        .freq_counter_done_i(fl[8]), .soft_source_0_flag_i(fl[9]),
        .soft_source_1_flag_i(fl[10]), .irq_ack_i, .irq_ret_i,
        .sfr_rdata_o, .sfr_bit_rdata_o, .irq_req_o, .irq_high_o, .irq_id_o,
        .in_service_o
    );

    ieu_core_model u_ieu_core_model (
        .sys_clk_i, .rst_i, .irq_req_i(irq_req_o), .svc_len_i,
        .irq_ack_o(irq_ack_i), .irq_ret_o(irq_ret_i)
    );

    // 100 MHz clock
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic int rdv(input logic [7:0] a);
        case (a)
            8'ha8: return m_en;
            8'hb8: return m_pri | 128;
            8'he6: return m_ext << 2;
            default: return 0;
        endcase
    endfunction : rdv

    // Reference model; arbitration sees the state from before this edge
    always @(posedge sys_clk_i) begin
        int sv, ev, lv, w, ackd;
        if (rst_i) begin
            {m_en, m_pri, m_ext, m_svc, m_rd, m_brd} = '0;
            {m_req, m_hi, m_id} = '0;
        end else begin
            sv = fl[4:0] | ((fl[5] | fl[6]) << 5) | (fl[10:7] << 6);
            ev = m_en[7] ? (m_en & 127) | (m_ext << 7) : 0;
            lv = m_pri & 127;
            w = -1;
            for (int h = 1; h >= 0; h--)
                for (int i = 0; i < 10; i++)
                    if (w < 0 && sv[i] && ev[i] && lv[i] == h && !m_svc[1]
                        && (!m_svc[0] || h == 1)) w = i;
            if (sfr_rd_i) m_rd = rdv(sfr_addr_i);
            if (sfr_bit_rd_i)
                m_brd = rdv({sfr_bit_addr_i[7:3], 3'h0}) >> sfr_bit_addr_i[2:0];
            m_brd = m_brd & 1;
            if (sfr_wr_i) begin
                case (sfr_addr_i)
                    8'ha8: m_en = sfr_wdata_i;
                    8'hb8: m_pri = sfr_wdata_i & 127;
                    8'he6: m_ext = (sfr_wdata_i >> 2) & 7;
                    default: ;
                endcase
            end
            // A bit write lands after a byte write of the same cycle
            if (sfr_bit_wr_i && sfr_bit_addr_i[7:3] == 5'h15)
                m_en[sfr_bit_addr_i[2:0]] = sfr_bit_wdata_i;
            if (sfr_bit_wr_i && sfr_bit_addr_i[7:3] == 5'h17 &&
                sfr_bit_addr_i[2:0] != 3'h7)
                m_pri[sfr_bit_addr_i[2:0]] = sfr_bit_wdata_i;
            ackd = irq_ack_i && m_req;
            if (irq_ret_i) m_svc = m_svc[1] ? m_svc & 1 : 0;
            if (ackd) m_svc[m_hi] = 1;
            m_req = w >= 0 && !ackd;
            if (m_req) begin
                m_hi = lv[w];
                m_id = w < 7 ? w : w + 2;
            end
        end
    end

    task automatic chk(input string nm, input logic [7:0] ex, got);
        checks_done++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Compare every settled output against the model; winner and level only while the model has a request up
    always @(negedge sys_clk_i) begin
        if (chk_on) begin
            chk("byte read", m_rd, sfr_rdata_o);
            chk("bit read", m_brd, sfr_bit_rdata_o);
            chk("req", m_req, irq_req_o);
            chk("in service", m_svc, in_service_o);
            if (m_req) begin
                chk("winner", m_id, irq_id_o);
                chk("level", m_hi, irq_high_o);
            end
        end
    end

    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        sfr_rd_i <= 1'b0;
    endtask : rd

    task automatic bit_op(input logic [7:0] a, input logic v, wr_en);
        @(posedge sys_clk_i);
        sfr_bit_addr_i <= a;
        sfr_bit_wdata_i <= v;
        sfr_bit_wr_i <= wr_en;
        sfr_bit_rd_i <= !wr_en;
        @(posedge sys_clk_i);
        sfr_bit_wr_i <= 1'b0;
        sfr_bit_rd_i <= 1'b0;
    endtask : bit_op

    task automatic close_out;
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    // Watchdog well past the expected run of about 3400 cycles
    initial begin
        repeat (10000) @(posedge sys_clk_i);
        mismatches++;
        close_out();
    end

    // Main sequence: registers, per-source walk, then random traffic
    initial begin
        logic [7:0] ba;
        logic [31:0] r;
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk_on <= 1'b1;
        foreach (maps[k]) rd(maps[k]);
        wr(8'ha8, 8'hff);
        wr(8'hb8, 8'hff);
        wr(8'he6, 8'hfc);
        wr(8'h00, 8'hff);
        foreach (maps[k]) rd(maps[k]);
        for (int i = 0; i < 17; i++) begin
            ba = (i < 8) ? 8'ha8 + 8'(i) : 8'hb0 + 8'(i);
            bit_op(ba, i[1], 1'b1);
            bit_op(ba, 1'b0, 1'b0);
        end
        for (int i = 0; i < 11; i++) begin
            svc_len_i <= 4'(i);
            wr(8'hb8, i[0] ? 8'hff : 8'h00);
            wr(8'he6, 8'h1c);
            wr(8'ha8, 8'h7f);
            fl <= 11'(1 << i);
            repeat (4) @(posedge sys_clk_i);
            bit_op(8'haf, 1'b1, 1'b1);
            repeat (12) @(posedge sys_clk_i);
            fl <= 11'h000;
            wr(8'ha8, 8'h00);
        end
        // Random flags, register traffic and service lengths
        repeat (3000) begin
            @(posedge sys_clk_i);
            r = $random(seed);
            if (r[2:0] == 3'h0) fl <= 11'($random(seed));
            svc_len_i <= r[11:8];
            sfr_wr_i <= r[6:4] == 3'h0;
            sfr_rd_i <= r[6:4] == 3'h1;
            sfr_bit_wr_i <= r[6:4] == 3'h2;
            sfr_bit_rd_i <= r[6:4] == 3'h3;
            sfr_addr_i <= maps[r[13:12]];
            sfr_wdata_i <= r[13:12] == 2'h2 ? r[23:16] & 8'hfc : r[23:16];
            sfr_bit_addr_i <= {r[24] ? 5'h15 : 5'h17, r[27:25]};
            sfr_bit_wdata_i <= r[28];
        end
        @(posedge sys_clk_i);
        {sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_rd_i} <= 4'h0;
        repeat (4) @(posedge sys_clk_i);
        close_out();
    end
endmodule : interrupt_enable_priority_unit_test
